// >>> verilog/rds_sequencer.sv
// Reset delay sequencer: gathers reset sources, times the release of the
// system reset, gates code execution on a valid clock and starts the monitor.
// Assumes every input is synchronous to i_ref_clk and i_osc_edge is a
// one-cycle pulse per oscillator period, supplied by the oscillator block.
`timescale 1ns/1ps

module rds_sequencer
  import rds_pkg::*;
#(
  parameter int unsigned POWER_UP_TIMER_TICKS = rds_pkg::POWER_UP_TIMER_US,
  parameter int unsigned MON_TICKS  = rds_pkg::MON_START_US
) (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_reset_n,
  input  wire rds_pkg::rds_src_s     i_src,
  input  wire logic                  i_reg_en,
  input  wire logic                  i_wake,
  input  wire rds_pkg::rds_osc_cfg_s i_osc_cfg,
  input  wire logic                  i_osc_edge,
  input  wire logic                  i_pll_lock,
  input  wire logic                  i_mon_en,
  input  wire logic                  i_clk_valid,
  output logic                       o_system_reset_line,
  output logic                       o_cpu_run,
  output logic                       o_monitor_active,
  output logic                       o_clk_fail_trap,
  output logic                       o_use_fast_rc,
  output logic [2:0]                 o_sel_osc,
  output logic [15:0]                o_reset_cause,
  output logic [15:0]                o_osc_ctl_reset
);

  import rds_pkg::*;

  localparam logic [DLY_W-1:0]     PON_T  = DLY_W'(POWER_ON_US);
  localparam logic [DLY_W-1:0]     STU_T  = DLY_W'(STARTUP_US);
  localparam logic [DLY_W-1:0]     POWER_UP_TIMER_T = DLY_W'(POWER_UP_TIMER_TICKS);
  localparam logic [DLY_W-1:0]     RST_T  = DLY_W'(INT_RST_US);
  localparam logic [DLY_W-1:0]     LCK_T  = DLY_W'(PLL_LOCK_US);
  localparam logic [DLY_W-1:0]     MON_T  = DLY_W'(MON_TICKS);
  localparam logic [OSC_CNT_W-1:0] OST_T  = OSC_CNT_W'(OSC_START_CNT);
  localparam logic [TICK_W-1:0]    TICK_T = TICK_W'(TICK_CYC - 1);

  // Start-up term: short with the regulator on, power-up timer otherwise.
  function automatic logic [DLY_W-1:0] startup_term(input logic reg_en);
    return reg_en ? STU_T : POWER_UP_TIMER_T; // [R5]
  endfunction

  // Total release delay for a reset kind.
  function automatic logic [DLY_W-1:0] release_delay(input rds_kind_e kind,
                                                     input logic reg_en);
    unique case (kind)
      KIND_POR: return PON_T + startup_term(reg_en) + RST_T; // [R3] [R4]
      KIND_BOR: return startup_term(reg_en) + RST_T;         // [R3]
      default:  return RST_T;                                // [R7]
    endcase
  endfunction

  rds_state_e          state_ff;
  rds_state_e          nxt_state;
  rds_kind_e           kind_ff;
  rds_kind_e           src_kind;
  logic                any_src;
  logic [TICK_W-1:0]   tick_cnt_ff;
  logic                tick;
  logic [2:0]          sel_osc_ff;
  logic                use_frc_ff;
  logic                trap_ff;
  logic [15:0]         cause_ff;
  logic [15:0]         osc_rst_ff;
  logic                hold;
  logic                power_kind;
  logic                needs_ost;
  logic                needs_lock;
  logic                needs_mon;
  logic                clk_ready;
  logic                mon_on;
  logic [DLY_W-1:0]    sys_cnt;
  logic                sys_done;
  logic                lock_done;
  logic                mon_done;
  logic                wake_done;
  logic [OSC_CNT_W-1:0] ost_cnt;
  logic                ost_done;

  assign any_src  = |i_src;
  assign src_kind = i_src.por ? KIND_POR : (i_src.bor ? KIND_BOR : KIND_OTHER);
  assign hold     = (state_ff == ST_HOLD);

  // Free-running 1 us timebase; it never stops, so every delay keeps its scale.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_cnt_ff <= '0;
    end else if (tick) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + TICK_W'(1); // [R18]
    end
  end

  assign tick = (tick_cnt_ff == TICK_T);

  // A new source during delay or run restarts the hold at once.
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_HOLD:  if (!any_src) nxt_state = ST_DELAY;
      ST_DELAY: if (any_src) nxt_state = ST_HOLD;
                else if (sys_done) nxt_state = ST_DONE; // [R1]
      ST_DONE:  if (any_src) nxt_state = ST_HOLD;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= ST_HOLD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // The strongest kind seen while holding decides the release delay.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      kind_ff <= KIND_POR;
    end else if (any_src) begin
      if (!hold || (src_kind > kind_ff)) begin
        kind_ff <= src_kind; // [R3]
      end
    end
  end

  // Clock source at reset; switching off always follows the configuration.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_osc_ff <= OSC_FRC;
    end else if (any_src) begin
      if (i_src.por || i_src.bor || !i_osc_cfg.switch_en) begin
        sel_osc_ff <= i_osc_cfg.init_sel; // [R17]
      end else begin
        sel_osc_ff <= i_osc_cfg.cur_sel;  // [R17]
      end
    end
  end

  // Release-delay counter, reloaded every cycle the sequencer is in ST_HOLD.
  rds_down_counter #(.W(DLY_W)) u_sys_cnt (
    .i_ref_clk  (i_ref_clk),
    .i_reset_n  (i_reset_n),
    .i_load     (hold),
    .i_load_val (release_delay(kind_ff, i_reg_en)),
    .i_step     (tick),
    .o_count    (sys_cnt),
    .o_done     (sys_done)
  );

  assign power_kind = (kind_ff != KIND_OTHER);
  assign needs_lock = (sel_osc_ff == OSC_FRC_PLL) || (sel_osc_ff == OSC_PRI_PLL);
  assign needs_ost  = (sel_osc_ff == OSC_SEC) ||
                      (i_osc_cfg.pri_crystal &&
                       ((sel_osc_ff == OSC_PRI) || (sel_osc_ff == OSC_PRI_PLL)));

  // Start-up count and lock wait load with the hold and run during the delay.
  rds_down_counter #(.W(OSC_CNT_W)) u_ost_cnt (
    .i_ref_clk  (i_ref_clk),
    .i_reset_n  (i_reset_n),
    .i_load     (hold),
    .i_load_val (OST_T),
    .i_step     (i_osc_edge), // [R8] [R2]
    .o_count    (ost_cnt),
    .o_done     (ost_done)
  );

  rds_down_counter #(.W(DLY_W)) u_lock_cnt (
    .i_ref_clk  (i_ref_clk),
    .i_reset_n  (i_reset_n),
    .i_load     (hold),
    .i_load_val (LCK_T),
    .i_step     (tick), // [R2]
    .o_count    (),
    .o_done     (lock_done)
  );

  // Clock delays only follow power resets; other resets keep a running clock.
  assign clk_ready = !power_kind ||
                     ((!needs_ost || ost_done) &&
                      (!needs_lock || (lock_done && i_pll_lock))); // [R9]

  // Monitor start delay counts from release, only for crystal or PLL sources.
  assign needs_mon = power_kind && (needs_ost || needs_lock); // [R10] [R11]

  rds_down_counter #(.W(DLY_W)) u_mon_cnt (
    .i_ref_clk  (i_ref_clk),
    .i_reset_n  (i_reset_n),
    .i_load     (state_ff != ST_DONE),
    .i_load_val (MON_T),
    .i_step     (tick), // [R10]
    .o_count    (),
    .o_done     (mon_done)
  );

  assign mon_on = (state_ff == ST_DONE) && (!needs_mon || mon_done); // [R11]

  // Wake from sleep with the regulator on repeats the start-up delay.
  rds_down_counter #(.W(DLY_W)) u_wake_cnt (
    .i_ref_clk  (i_ref_clk),
    .i_reset_n  (i_reset_n),
    .i_load     (i_wake && i_reg_en && !hold),
    .i_load_val (STU_T),
    .i_step     (tick), // [R6]
    .o_count    (),
    .o_done     (wake_done)
  );

  // Clock failure at monitor start falls back to fast RC and raises a trap.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      use_frc_ff <= 1'b0;
      trap_ff    <= 1'b0;
    end else if (any_src) begin
      use_frc_ff <= 1'b0;
      trap_ff    <= 1'b0;
    end else begin
      trap_ff <= mon_on && i_mon_en && !i_clk_valid && !use_frc_ff; // [R13]
      if (mon_on && i_mon_en && !i_clk_valid) begin
        use_frc_ff <= 1'b1; // [R13]
      end
    end
  end

  // Reset cause flags: each source sets its own bit; power-on reloads the reset value, brownout sets BOR and clears all others but EXT and POR.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cause_ff <= CAUSE_RST_VAL;
    end else if (i_src.por) begin
      cause_ff <= CAUSE_RST_VAL; // [R14]
    end else begin
      if (i_src.bor) begin
        cause_ff[CAUSE_TRAP]  <= 1'b0;
        cause_ff[CAUSE_IOPU]  <= 1'b0;
        cause_ff[CAUSE_SW]    <= 1'b0;
        cause_ff[CAUSE_WDTO]  <= 1'b0;
        cause_ff[CAUSE_SLEEP] <= 1'b0;
        cause_ff[CAUSE_IDLE]  <= 1'b0;
        cause_ff[CAUSE_BOR]   <= 1'b1; // [R14]
      end
      if (i_src.trap) cause_ff[CAUSE_TRAP] <= 1'b1;
      if (i_src.iopu) cause_ff[CAUSE_IOPU] <= 1'b1;
      if (i_src.master_clear_pin) cause_ff[CAUSE_EXT]  <= 1'b1;
      if (i_src.swr)  cause_ff[CAUSE_SW]   <= 1'b1;
      if (i_src.wdt)  cause_ff[CAUSE_WDTO] <= 1'b1;
    end
  end

  // Oscillator control reset image from the chosen source and configuration.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      osc_rst_ff <= '0;
    end else begin
      osc_rst_ff <= '0;
      osc_rst_ff[OSCCTL_CUR_LSB +: 3] <= use_frc_ff ? OSC_FRC : sel_osc_ff; // [R15]
      osc_rst_ff[OSCCTL_NEW_LSB +: 3] <= i_osc_cfg.init_sel;                // [R15]
    end
  end

  // Reset asserts combinationally so no source waits a cycle for it.
  assign o_system_reset_line = any_src || (state_ff != ST_DONE); // [R16]
  assign o_cpu_run           = !o_system_reset_line && clk_ready && wake_done; // [R12]
  assign o_monitor_active    = mon_on && i_mon_en;
  assign o_clk_fail_trap     = trap_ff;
  assign o_use_fast_rc       = use_frc_ff;
  assign o_sel_osc           = use_frc_ff ? OSC_FRC : sel_osc_ff;
  assign o_reset_cause       = cause_ff;
  assign o_osc_ctl_reset     = osc_rst_ff;

  property p_src_asserts;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      any_src |-> o_system_reset_line;
  endproperty
  a_src_asserts: assert property (p_src_asserts) // [R16]
    else $error("Reset source active but system reset released.");

  property p_hold_until_done;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      (state_ff == ST_DELAY && !sys_done) |=> o_system_reset_line;
  endproperty
  a_hold_until_done: assert property (p_hold_until_done) // [R1]
    else $error("System reset released before delay expired.");

  property p_por_delay;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      (hold && !any_src && kind_ff == KIND_POR && i_reg_en)
        |=> (sys_cnt == PON_T + STU_T + RST_T);
  endproperty
  a_por_delay: assert property (p_por_delay) // [R3]
    else $error("Power-on release delay has the wrong length.");

  property p_other_delay;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      (hold && !any_src && kind_ff == KIND_OTHER) |=> (sys_cnt == RST_T);
  endproperty
  a_other_delay: assert property (p_other_delay) // [R7]
    else $error("Non-power release delay is not the internal reset time.");

  property p_ost_load;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      hold |=> (ost_cnt == OST_T);
  endproperty
  a_ost_load: assert property (p_ost_load) // [R8]
    else $error("Start-up counter not loaded with its full count.");

  property p_run_needs_clock;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      o_cpu_run |-> (clk_ready && state_ff == ST_DONE && !any_src);
  endproperty
  a_run_needs_clock: assert property (p_run_needs_clock) // [R12]
    else $error("Execution allowed without a released clock.");

  property p_clk_fail;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      (mon_on && i_mon_en && !i_clk_valid && !use_frc_ff && !any_src)
        |=> (o_clk_fail_trap && o_use_fast_rc && o_sel_osc == OSC_FRC);
  endproperty
  a_clk_fail: assert property (p_clk_fail) // [R13]
    else $error("Clock failure did not trap and select fast RC.");

  property p_no_mon_delay;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      (state_ff == ST_DONE && kind_ff == KIND_OTHER) |-> mon_on;
  endproperty
  a_no_mon_delay: assert property (p_no_mon_delay) // [R11]
    else $error("Monitor start delayed after a non-power reset.");

  property p_por_select;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      i_src.por |=> (sel_osc_ff == $past(i_osc_cfg.init_sel));
  endproperty
  a_por_select: assert property (p_por_select) // [R17]
    else $error("Power-on reset did not take the configured oscillator.");

  property p_wake_stall;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      (i_wake && i_reg_en && state_ff == ST_DONE && !any_src)
        |=> !o_cpu_run [*2];
  endproperty
  a_wake_stall: assert property (p_wake_stall) // [R6]
    else $error("Wake from sleep skipped the start-up delay.");

endmodule // rds_sequencer

// >>> verilog/rds_pkg.sv
// Constants, codes and carriers shared by the reset delay sequencer.
// Assumes a 200 MHz free-running reference clock; all delays but the oscillator start-up count 1 us ticks.
//
// Functional notes
// R1: System reset stays asserted until power-on and power-up timer delays end.
// R2: Oscillator start-up count and PLL lock wait run alongside the reset delay.
// R3: Power-on delay is power-on + start-up + internal reset; brownout drops power-on.
// R4: Power-on delay term is nominally 10 us.
// R5: Start-up delay is 20 us with regulator on, 64 ms power-up timer otherwise.
// R6: Start-up delay also applies on leaving powered-down states, e.g. sleep wake; the code repeats it on wake only with the regulator on.
// R7: Pin, watchdog, software, opcode, register and trap resets use only 20 us.
// R8: Crystal and secondary sources wait 1024 oscillator periods before clock release.
// R9: Clock delay after power resets depends on source: none, lock, start-up, both.
// R10: Crystal or PLL sources insert a monitor start delay after reset release.
// R11: No monitor start delay for plain external/RC clocks or any non-power reset.
// R12: No instruction runs until a valid clock has been released.
// R13: Enabled monitor checks clock at release; failure selects fast RC and traps.
// R14: Only reset cause and oscillator control registers have type-dependent resets.
// R15: Oscillator control reset value comes from reset type and configuration bits.
// R16: Any active reset source asserts system reset at once; delays only on release.
// R17: With switching on, power resets use config select, others keep current field.
// R18: Each delay is a tunable down-counter on an always-running timebase.

package rds_pkg;

  // Timebase: one tick per microsecond.
  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned TICK_CYC       = CLK_MHZ * 1;
  localparam int unsigned TICK_W         = 8;

  // Nominal delays in microseconds.
  localparam int unsigned POWER_ON_US    = 10;
  localparam int unsigned STARTUP_US     = 20;
  localparam int unsigned POWER_UP_TIMER_US        = 64000;
  localparam int unsigned INT_RST_US     = 20;
  localparam int unsigned PLL_LOCK_US    = 20;
  localparam int unsigned MON_START_US   = 500;
  localparam int unsigned DLY_W          = 17;

  // Oscillator start-up count in oscillator periods.
  localparam int unsigned OSC_START_CNT  = 1024;
  localparam int unsigned OSC_CNT_W      = 11;

  // Oscillator select codes carried by the configuration and current fields.
  localparam logic [2:0] OSC_FRC         = 3'h0;
  localparam logic [2:0] OSC_FRC_PLL     = 3'h1;
  localparam logic [2:0] OSC_PRI         = 3'h2;
  localparam logic [2:0] OSC_PRI_PLL     = 3'h3;
  localparam logic [2:0] OSC_SEC         = 3'h4;
  localparam logic [2:0] OSC_LOW_POWER_RC_OSC        = 3'h5;

  // Reset cause register bit positions and power-on value.
  localparam int unsigned CAUSE_TRAP     = 15;
  localparam int unsigned CAUSE_IOPU     = 14;
  localparam int unsigned CAUSE_EXT      = 7;
  localparam int unsigned CAUSE_SW       = 6;
  localparam int unsigned CAUSE_WDTO     = 4;
  localparam int unsigned CAUSE_SLEEP    = 3;
  localparam int unsigned CAUSE_IDLE     = 2;
  localparam int unsigned CAUSE_BOR      = 1;
  localparam int unsigned CAUSE_POR      = 0;
  localparam logic [15:0] CAUSE_RST_VAL  = 16'h0003;

  // Oscillator control register reset layout: current at 14:12, new at 10:8.
  localparam int unsigned OSCCTL_CUR_LSB = 12;
  localparam int unsigned OSCCTL_NEW_LSB = 8;

  // Reset kind, ordered so that the stronger kind compares larger.
  typedef enum logic [1:0] {
    KIND_OTHER = 2'h0,
    KIND_BOR   = 2'h1,
    KIND_POR   = 2'h2
  } rds_kind_e;

  // Sequencer states, one-hot.
  typedef enum logic [2:0] {
    ST_HOLD  = 3'b001,
    ST_DELAY = 3'b010,
    ST_DONE  = 3'b100
  } rds_state_e;

  // Reset requests from every source.
  typedef struct packed {
    logic por;
    logic bor;
    logic master_clear_pin;
    logic wdt;
    logic swr;
    logic iopu;
    logic trap;
  } rds_src_s;

  // Oscillator configuration as seen at reset.
  typedef struct packed {
    logic       switch_en;
    logic       pri_crystal;
    logic [2:0] init_sel;
    logic [2:0] cur_sel;
  } rds_osc_cfg_s;

endpackage : rds_pkg

// >>> verilog/rds_down_counter.sv
// Loadable down-counter that decrements on an enable pulse and stops at zero.
// Assumes the load and step inputs are synchronous to the single clock.
`timescale 1ns/1ps

module rds_down_counter #(
  parameter int unsigned W = 17
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_reset_n,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_load_val,
  input  wire logic         i_step,
  output logic      [W-1:0] o_count,
  output logic              o_done
);

  logic [W-1:0] count_ff;

  // Load wins over a step so a fresh request always restarts the full delay.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_ff <= '0;
    end else if (i_load) begin
      count_ff <= i_load_val;
    end else if (i_step && (count_ff != '0)) begin
      count_ff <= count_ff - W'(1); // [R18]
    end
  end

  assign o_count = count_ff;
  assign o_done  = (count_ff == '0);

endmodule // rds_down_counter

// >>> sim/rds_osc_model.sv
// Oscillator and PLL model that stands at the clock side of the reset delay sequencer.
// Assumes the bench starts and stops the oscillator on the reference clock.
`timescale 1ns/1ps

module rds_osc_model #(
  parameter int unsigned PERIOD   = 4,
  parameter int unsigned LOCK_CYC = 600
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_osc_on,
  output logic             o_osc_edge,
  output logic             o_pll_lock,
  output logic             o_clk_valid,
  output logic [15:0]      o_edge_cnt
);
  int unsigned div_ff;
  int unsigned lock_ff;

  // Start from a quiet oscillator so the sequencer never sees unknown pulses.
  initial begin
    div_ff = 0;
    lock_ff = 0;
    o_osc_edge = 1'b0;
    o_edge_cnt = 16'h0000;
  end

  // One pulse per period; a stopped crystal gives none, and the edge count clears to zero.
  // A plain always is used because the initial block also gives these a value.
  always @(posedge i_ref_clk) begin
    div_ff     <= (!i_osc_on || div_ff == PERIOD - 1) ? 0 : div_ff + 1;
    o_osc_edge <= i_osc_on && (div_ff == PERIOD - 1);
    o_edge_cnt <= i_osc_on ? o_edge_cnt + {15'h0000, o_osc_edge} : 16'h0000;
  end

  // Lock comes only after the loop has run a while and is lost when it stops.
  always @(posedge i_ref_clk) begin
    lock_ff <= i_osc_on ? ((lock_ff < LOCK_CYC) ? lock_ff + 1 : lock_ff) : 0;
  end

  assign o_pll_lock  = (lock_ff >= LOCK_CYC);
  assign o_clk_valid = i_osc_on;
endmodule // rds_osc_model

// >>> sim/rds_sequencer_tb.sv
// Self-checking bench for the reset delay sequencer with an oscillator model.
// Assumes shortened power-up and monitor counts; one tick is 200 reference cycles.
`timescale 1ns/1ps

module rds_sequencer_tb;
  import rds_pkg::*;
  localparam int POWER_UP_TIMER   = 50;
  localparam int MON    = 5;
  localparam int T_OTH  = INT_RST_US;
  localparam int T_BOR  = STARTUP_US + INT_RST_US;
  localparam int T_POR  = POWER_ON_US + T_BOR;
  localparam int T_BOR0 = POWER_UP_TIMER + INT_RST_US;
  typedef struct {
    logic [6:0] src;
    logic       reg_en;
    logic [2:0] init;
    int         ticks;
  } rds_row_s;

  logic         i_ref_clk;
  logic         i_reset_n;
  rds_src_s     src;
  logic         reg_en;
  logic         wake;
  rds_osc_cfg_s cfg;
  logic         osc_on;
  logic         mon_en;
  logic         osc_edge;
  logic         pll_lock;
  logic         clk_valid;
  logic [15:0]  edge_cnt;
  logic         o_system_reset_line;
  logic         o_cpu_run;
  logic         o_monitor_active;
  logic         o_clk_fail_trap;
  logic         o_use_fast_rc;
  logic [2:0]   o_sel_osc;
  logic [15:0]  o_reset_cause;
  logic [15:0]  o_osc_ctl_reset;
  int           err_total = 0;
  int           n_tests = 0;
  int           cyc_cnt = 0;
  logic [15:0]  exp_cause;
  // Ordinary reset kinds: bit order is por, bor, master_clear_pin, wdt, swr, iopu, trap.
  rds_row_s rows [8] = '{'{7'h20, 1'b1, OSC_FRC_PLL, T_BOR}, '{7'h10, 1'b1, OSC_FRC_PLL, T_OTH},
                         '{7'h08, 1'b1, OSC_FRC_PLL, T_OTH}, '{7'h04, 1'b1, OSC_FRC_PLL, T_OTH},
                         '{7'h02, 1'b1, OSC_FRC_PLL, T_OTH}, '{7'h01, 1'b1, OSC_FRC_PLL, T_OTH},
                         '{7'h20, 1'b0, OSC_LOW_POWER_RC_OSC, T_BOR0}, '{7'h40, 1'b1, OSC_LOW_POWER_RC_OSC, T_POR}};

  rds_sequencer #(.POWER_UP_TIMER_TICKS(POWER_UP_TIMER), .MON_TICKS(MON)) u_dut (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_src(src), .i_reg_en(reg_en),
    .i_wake(wake), .i_osc_cfg(cfg), .i_osc_edge(osc_edge), .i_pll_lock(pll_lock),
    .i_mon_en(mon_en), .i_clk_valid(clk_valid), .o_system_reset_line(o_system_reset_line),
    .o_cpu_run(o_cpu_run), .o_monitor_active(o_monitor_active),
    .o_clk_fail_trap(o_clk_fail_trap), .o_use_fast_rc(o_use_fast_rc), .o_sel_osc(o_sel_osc),
    .o_reset_cause(o_reset_cause), .o_osc_ctl_reset(o_osc_ctl_reset));

  rds_osc_model u_osc (.i_ref_clk(i_ref_clk), .i_osc_on(osc_on), .o_osc_edge(osc_edge),
    .o_pll_lock(pll_lock), .o_clk_valid(clk_valid), .o_edge_cnt(edge_cnt));

  // 200 MHz reference clock.
  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  task automatic conclude();
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The tick is free running, so a measured delay may be one tick short or long.
  task automatic wait_for(input int what, input int ticks);
    int n = 0;
    @(posedge i_ref_clk);
    #1;
    while (n < 30000 && (what == 0 ? o_system_reset_line !== 1'b0 :
           what == 1 ? o_cpu_run !== 1'b1 : o_clk_fail_trap !== 1'b1)) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    n_tests++;
    if (n < ticks * 200 - 200 || n > ticks * 200 + 210) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, n, ticks * 200);
    end
  endtask

  // Expected cause flags: power-on resets all, brownout clears most, others add a bit.
  function automatic logic [15:0] nxt_cause(input logic [15:0] c, input logic [6:0] s);
    if (s[6]) begin
      return CAUSE_RST_VAL;
    end
    if (s[5]) begin
      c = (c & ~16'hC05C) | 16'h0002;
    end
    c = c | {s[0], s[1], 6'h00, s[4], s[2], 1'b0, s[3], 4'h0};
    return c;
  endfunction

  // A hang is cut short here, at a cycle count only a little above the whole planned run.
  always @(posedge i_ref_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 100000) begin
      err_total++;
      conclude();
    end
  end

  initial begin
    logic pwr;
    i_reset_n = 1'b0;
    src = '0;
    reg_en = 1'b1;
    wake = 1'b0;
    cfg = '{1'b1, 1'b0, OSC_FRC_PLL, OSC_SEC};
    osc_on = 1'b1;
    mon_en = 1'b1;
    exp_cause = CAUSE_RST_VAL;
    repeat (6) @(posedge i_ref_clk);
    #1;
    chk(o_reset_cause, CAUSE_RST_VAL);
    chk(o_osc_ctl_reset, 16'h0000);
    chk(o_system_reset_line, 1'b1);
    chk(o_cpu_run, 1'b0);
    @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    wait_for(0, T_POR);
    foreach (rows[i]) begin
      @(posedge i_ref_clk);
      src <= rds_src_s'(rows[i].src);
      reg_en <= rows[i].reg_en;
      cfg.init_sel <= rows[i].init;
      #1 chk(o_system_reset_line, 1'b1);
      repeat (2) @(posedge i_ref_clk);
      src <= '0;
      exp_cause = nxt_cause(exp_cause, rows[i].src);
      pwr = (rows[i].src[6:5] != 2'h0);
      wait_for(0, rows[i].ticks);
      repeat (2) @(posedge i_ref_clk);
      #1 chk(o_cpu_run, 1'b1);
      chk(o_monitor_active, !(pwr && rows[i].init == OSC_FRC_PLL));
      chk(o_sel_osc, pwr ? rows[i].init : OSC_SEC);
      chk(o_osc_ctl_reset[10:8], rows[i].init);
      chk(o_osc_ctl_reset[14:12], pwr ? rows[i].init : OSC_SEC);
      chk(o_reset_cause, exp_cause);
    end
    // Wake with the regulator on stalls execution; with it off nothing changes.
    @(posedge i_ref_clk);
    reg_en <= 1'b1;
    wake <= 1'b1;
    @(posedge i_ref_clk);
    wake <= 1'b0;
    #1 chk(o_cpu_run, 1'b0);
    wait_for(1, STARTUP_US);
    @(posedge i_ref_clk);
    reg_en <= 1'b0;
    wake <= 1'b1;
    @(posedge i_ref_clk);
    wake <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    #1 chk(o_cpu_run, 1'b1);
    // Crystal that has not started: reset releases but execution waits for the count.
    @(posedge i_ref_clk);
    osc_on <= 1'b0;
    mon_en <= 1'b0;
    reg_en <= 1'b1;
    cfg <= '{1'b1, 1'b1, OSC_PRI, OSC_SEC};
    src <= rds_src_s'(7'h20);
    repeat (3) @(posedge i_ref_clk);
    src <= '0;
    wait_for(0, T_BOR);
    repeat (400) @(posedge i_ref_clk);
    #1 chk(o_cpu_run, 1'b0);
    @(posedge i_ref_clk);
    osc_on <= 1'b1;
    while (edge_cnt !== 16'h03FF) begin
      @(posedge i_ref_clk);
      #1;
    end
    @(posedge i_ref_clk);
    #1 chk(o_cpu_run, 1'b0);
    while (edge_cnt !== 16'h0400) begin
      @(posedge i_ref_clk);
      #1;
    end
    repeat (3) @(posedge i_ref_clk);
    #1 chk(o_cpu_run, 1'b1);
    // Dead crystal with the monitor on: delayed start, then trap and fallback.
    @(posedge i_ref_clk);
    osc_on <= 1'b0;
    mon_en <= 1'b1;
    src <= rds_src_s'(7'h20);
    repeat (3) @(posedge i_ref_clk);
    src <= '0;
    wait_for(0, T_BOR);
    chk(o_monitor_active, 1'b0);
    wait_for(2, MON);
    chk(o_use_fast_rc, 1'b1);
    chk(o_sel_osc, OSC_FRC);
    @(posedge i_ref_clk);
    #1 chk(o_clk_fail_trap, 1'b0);
    conclude();
  end
endmodule // rds_sequencer_tb
